// *** design/rcn_pkg.sv ***
// Purpose: constants for the reset and serial memory control register
// Assumes: a 32-bit control register plus irq status and mask words behind an apb slave, 20 mhz pclk
// Notes:   offsets of the register, status and mask words are local choices
`default_nettype none
package rcn_pkg;
  localparam logic [7:0]  RCN_CTRL_OFS    = 8'h00;
  localparam logic [7:0]  RCN_IRQ_STAT_OFS = 8'h04;
  localparam logic [7:0]  RCN_IRQ_MASK_OFS = 8'h08;
  localparam int          RCN_BIT_ENABLE   = 31;
  localparam int          RCN_BIT_CMD_HI   = 30;
  localparam int          RCN_BIT_CMD_LO   = 29;
  localparam int          RCN_BIT_FAIL     = 28;
  localparam int          RCN_BIT_MBX_RST  = 27;
  localparam int          RCN_BIT_FIFO_RST = 25;
  localparam int          RCN_BIT_AO_RST   = 24;
  localparam int          RCN_PORT_LSB     = 16;
  localparam logic [31:0] RCN_CTRL_RESET   = 32'h0000_0000;
  localparam logic [1:0]  RCN_IRQ_RESET    = 2'h0;
  // interrupt events: bit 0 access done, bit 1 access failed
  localparam int          RCN_IRQ_DONE     = 0;
  localparam int          RCN_IRQ_FAIL     = 1;
  typedef enum logic [1:0] {
    RCN_CMD_ADDR_LO = 2'h0,
    RCN_CMD_ADDR_HI = 2'h1,
    RCN_CMD_WRITE   = 2'h2,
    RCN_CMD_READ    = 2'h3
  } rcn_cmd_type;
endpackage
`default_nettype wire

// *** design/rcn_reset_nvmem_ctrl.sv ***
// Purpose: host reset-control register with serial memory byte port
// Assumes: memory engine is outside, shared with the add-on side by the
//          arbiter here; add-on requests use a req/grant/done handshake
// Notes:   pulses to the mailbox and fifo last one cycle
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module rcn_reset_nvmem_ctrl
  import rcn_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // shared memory engine
  output logic             mem_start,
  output logic             mem_write,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_owner_addon,
  input  wire logic        mem_done,
  input  wire logic        mem_fail,
  input  wire logic [7:0]  mem_rdata,
  // add-on side request
  input  wire logic        addon_req,
  output logic             addon_grant,
  // side effects
  output logic             mbx_flag_reset,
  output logic             rd_fifo_reset,
  output logic             add_on_reset_out_n,
  output logic             irq
);
  import rcn_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic        wr_en;
  logic        rd_en;
  logic        ctrl_sel;
  logic [7:0]  addr_lo_r, addr_lo_nxt;
  logic [7:0]  addr_hi_r, addr_hi_nxt;
  logic [7:0]  port_r, port_nxt;
  logic        busy_r, busy_nxt;
  logic        fail_r, fail_nxt;
  logic        ao_rst_r, ao_rst_nxt;
  logic        host_pend_r, host_pend_nxt;
  logic        host_wr_r, host_wr_nxt;
  logic        owner_r, owner_nxt;
  logic        active_r, active_nxt;
  logic        start_r, start_nxt;
  logic        mbx_r, mbx_nxt;
  logic        fifo_r, fifo_nxt;
  logic [1:0]  stat_r, stat_nxt;
  logic [1:0]  mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        irq_r, irq_nxt;
  logic        ao_n_r, ao_n_nxt;
  logic        grant_r, grant_nxt;
  logic        host_go;
  logic        host_done;
  rcn_cmd_type cmd;

  function automatic logic [31:0] ctrl_view(input logic busy, input logic fail,
                                            input logic aor, input logic [7:0] port);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[RCN_BIT_ENABLE] = busy;
    v[RCN_BIT_FAIL]   = fail;
    v[RCN_BIT_AO_RST] = aor;
    v[RCN_PORT_LSB +: 8] = port;
    return v;
  endfunction

  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & penable & ~pwrite;
  assign ctrl_sel = (paddr == RCN_CTRL_OFS);
  assign cmd      = rcn_cmd_type'(pwdata[RCN_BIT_CMD_HI:RCN_BIT_CMD_LO]);

  ////////////////////////////////////////////////////////////////////////
  // arbiter events: host_go feeds the byte port group, host_done both the byte port and interrupt groups
  assign host_go   = ~active_r & host_pend_r;
  assign host_done = active_r & mem_done & ~owner_r;

  ////////////////////////////////////////////////////////////////////////
  // control word and host byte port
  always_comb begin
    addr_lo_nxt   = addr_lo_r;
    addr_hi_nxt   = addr_hi_r;
    port_nxt      = port_r;
    busy_nxt      = busy_r;
    fail_nxt      = fail_r;
    ao_rst_nxt    = ao_rst_r;
    host_pend_nxt = host_pend_r;
    host_wr_nxt   = host_wr_r;
    mbx_nxt       = 1'b0;
    fifo_nxt      = 1'b0;

    // mailbox and fifo clears are single-cycle pulses, no zero write needed
    if (wr_en && ctrl_sel) begin
      ao_rst_nxt = pwdata[RCN_BIT_AO_RST];
      mbx_nxt    = pwdata[RCN_BIT_MBX_RST];
      fifo_nxt   = pwdata[RCN_BIT_FIFO_RST];
      // byte port writes are ignored while an access runs
      if (pwdata[RCN_BIT_ENABLE] && !busy_r) begin
        // address bytes stay loaded, so a repeat access needs only the begin
        case (cmd)
          RCN_CMD_ADDR_LO: addr_lo_nxt = pwdata[RCN_PORT_LSB +: 8];
          RCN_CMD_ADDR_HI: addr_hi_nxt = pwdata[RCN_PORT_LSB +: 8];
          RCN_CMD_WRITE, RCN_CMD_READ: begin
            port_nxt      = pwdata[RCN_PORT_LSB +: 8];
            host_wr_nxt   = (cmd == RCN_CMD_WRITE);
            host_pend_nxt = 1'b1;
            busy_nxt      = 1'b1;
          end
          default: ;
        endcase
      end
    end

    // the flag goes when the engine takes the next host access, not at the
    // command write, so software can still read why the last one failed
    if (host_go) begin
      host_pend_nxt = 1'b0;
      fail_nxt      = 1'b0;
    end
    if (host_done) begin
      busy_nxt = 1'b0;
      if (mem_fail) begin
        fail_nxt = 1'b1;
      end else if (!host_wr_r) begin
        port_nxt = mem_rdata;
      end
    end
    // the pin has its own flop so no inverter sits between it and the bit
    ao_n_nxt = ~ao_rst_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_lo_r   <= 8'h00;
      addr_hi_r   <= 8'h00;
      port_r      <= 8'h00;
      busy_r      <= 1'b0;
      fail_r      <= 1'b0;
      ao_rst_r    <= 1'b0;
      ao_n_r      <= 1'b1;
      host_pend_r <= 1'b0;
      host_wr_r   <= 1'b0;
      mbx_r       <= 1'b0;
      fifo_r      <= 1'b0;
    end else begin
      addr_lo_r   <= addr_lo_nxt;
      addr_hi_r   <= addr_hi_nxt;
      port_r      <= port_nxt;
      busy_r      <= busy_nxt;
      fail_r      <= fail_nxt;
      ao_rst_r    <= ao_rst_nxt;
      ao_n_r      <= ao_n_nxt;
      host_pend_r <= host_pend_nxt;
      host_wr_r   <= host_wr_nxt;
      mbx_r       <= mbx_nxt;
      fifo_r      <= fifo_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one engine, two clients: host first, add-on otherwise; an access that
  // has begun is never cut short, so a long add-on access delays the host
  always_comb begin
    owner_nxt  = owner_r;
    active_nxt = active_r;
    start_nxt  = 1'b0;

    if (!active_r) begin
      if (host_pend_r) begin
        owner_nxt  = 1'b0;
        active_nxt = 1'b1;
        start_nxt  = 1'b1;
      end else if (addon_req) begin
        owner_nxt  = 1'b1;
        active_nxt = 1'b1;
        start_nxt  = 1'b1;
      end
    end else if (mem_done) begin
      active_nxt = 1'b0;
    end
    // grant stands for the whole add-on access and drops with its done
    grant_nxt = owner_nxt & active_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      owner_r     <= 1'b0;
      active_r    <= 1'b0;
      start_r     <= 1'b0;
      grant_r     <= 1'b0;
    end else begin
      owner_r     <= owner_nxt;
      active_r    <= active_nxt;
      start_r     <= start_nxt;
      grant_r     <= grant_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // a status read clears only the bits that reader was shown, so an event
  // landing between setup and access is kept; a new event still wins
  always_comb begin
    stat_nxt = stat_r;
    mask_nxt = mask_r;

    if (rd_en && paddr == RCN_IRQ_STAT_OFS) begin
      stat_nxt = stat_r & ~rdata_r[1:0];
    end
    if (wr_en && paddr == RCN_IRQ_MASK_OFS) begin
      mask_nxt = pwdata[1:0];
    end

    if (host_done) begin
      stat_nxt[RCN_IRQ_DONE] = 1'b1;
      if (mem_fail) begin
        stat_nxt[RCN_IRQ_FAIL] = 1'b1;
      end
    end
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r      <= RCN_IRQ_RESET;
      mask_r      <= RCN_IRQ_RESET;
      irq_r       <= 1'b0;
    end else begin
      stat_r      <= stat_nxt;
      mask_r      <= mask_nxt;
      irq_r       <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data is latched in the setup cycle and held through the access,
  // so prdata never moves while the master may be sampling it
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        RCN_CTRL_OFS:     rdata_nxt = ctrl_view(busy_r, fail_r, ao_rst_r, port_r);
        RCN_IRQ_STAT_OFS: rdata_nxt = {30'h0, stat_r};
        RCN_IRQ_MASK_OFS: rdata_nxt = {30'h0, mask_r};
        default:          rdata_nxt = 32'h0000_0000;
      endcase
    end else if (penable) begin
      rdata_nxt = rdata_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r     <= RCN_CTRL_RESET;
    end else begin
      rdata_r     <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // the engine sees the host operands at all times, even while the add-on owns it;
  // the add-on supplies its own operands through the engine directly
  // zero wait: every access completes in its first access cycle
  assign prdata             = rdata_r;
  assign pready             = 1'b1;
  assign pslverr            = 1'b0;
  assign mem_start          = start_r;
  assign mem_write          = host_wr_r;
  assign mem_addr           = {addr_hi_r, addr_lo_r};
  assign mem_wdata          = port_r;
  assign mem_owner_addon    = owner_r;
  assign addon_grant        = grant_r;
  assign mbx_flag_reset     = mbx_r;
  assign rd_fifo_reset      = fifo_r;
  assign add_on_reset_out_n = ao_n_r;
  assign irq                = irq_r;
endmodule
`default_nettype wire

// *** sim/rcn_props.sv ***
// Purpose: port assertions for the reset and memory port register
// Assumes: zero-wait apb slave
// Notes:   bound from the bench top file
`timescale 1ns/10ps
`default_nettype none
module rcn_props
  import rcn_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        mbx_flag_reset,
  input wire logic        rd_fifo_reset,
  input wire logic        add_on_reset_out_n
);
  wire logic wr_c = psel && penable && pwrite && paddr == RCN_CTRL_OFS;
  wire logic rd_c = psel && penable && !pwrite && paddr == RCN_CTRL_OFS;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_mbx_set; wr_c && pwdata[27] |=> mbx_flag_reset; endproperty
  a_mbx_set: assert property (p_mbx_set) else $error("no mailbox pulse");
  property p_mbx_one; mbx_flag_reset |=> !mbx_flag_reset; endproperty
  a_mbx_one: assert property (p_mbx_one) else $error("mailbox pulse long");
  property p_fifo_set; wr_c && pwdata[25] |=> rd_fifo_reset; endproperty
  a_fifo_set: assert property (p_fifo_set) else $error("no fifo pulse");
  property p_fifo_one; rd_fifo_reset |=> !rd_fifo_reset; endproperty
  a_fifo_one: assert property (p_fifo_one) else $error("fifo pulse long");
  property p_aor_set; wr_c && pwdata[24] |=> !add_on_reset_out_n; endproperty
  a_aor_set: assert property (p_aor_set) else $error("add-on reset idle");
  property p_aor_hold;
    !add_on_reset_out_n && !(wr_c && !pwdata[24]) |=> !add_on_reset_out_n;
  endproperty
  a_aor_hold: assert property (p_aor_hold) else $error("add-on reset dropped");
  property p_rd_zero; rd_c |-> prdata[27:25] == 3'h0 && prdata[15:0] == 16'h0000; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("reserved bits set");
  property p_rd_aor; rd_c |-> prdata[24] == !add_on_reset_out_n; endproperty
  a_rd_aor: assert property (p_rd_aor) else $error("bit 24 readback");
endmodule
`default_nettype wire

// *** sim/rcn_mem_model.sv ***
// Purpose: behavioural serial memory engine behind the register
// Assumes: one access at a time, started by a one-cycle start pulse
// Notes:   add-on accesses never write, so host data stays intact
`timescale 1ns/10ps
`default_nettype none
module rcn_mem_model (
  // engine side
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic        wr,
  input  wire logic        owner_addon,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  // test controls
  input  wire logic        slow,
  input  wire logic        fail_en,
  // answer
  output logic             done,
  output logic             fail,
  output logic      [7:0]  rdata
);
  // nine address bits are kept, so a lost high address byte shows up
  logic [7:0]  mem [512];
  logic [15:0] a;
  initial begin
    done  = 1'b0;
    fail  = 1'b0;
    rdata = 8'h00;
    forever begin
      @(posedge clk);
      if (start === 1'b1) begin
        a = addr;
        repeat (slow ? 4 : 0) @(posedge clk);
        done  <= 1'b1;
        fail  <= fail_en;
        rdata <= mem[a[8:0]];
        if (wr && !owner_addon && !fail_en) mem[a[8:0]] = wdata;
        @(posedge clk);
        done  <= 1'b0;
        fail  <= 1'b0;
        // data released: show something other than the byte just sent
        rdata <= ~rdata;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/rcn_reset_nvmem_ctrl_bench.sv ***
// Purpose: self-checking bench for the reset and memory port register
// Assumes: zero-wait apb, behavioural memory engine
// Notes:   add-on side is one request level driven here
`timescale 1ns/10ps
`default_nettype none
module rcn_reset_nvmem_ctrl_bench;
  import rcn_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        mem_start, mem_write, mem_owner_addon, mem_done, mem_fail;
  logic        addon_req, addon_grant, mbx_flag_reset, rd_fifo_reset, add_on_reset_out_n;
  logic        slow, fail_en, rd_err;
  logic [7:0]  paddr, mem_wdata, mem_rdata;
  logic [15:0] mem_addr;
  logic [31:0] pwdata, prdata, rd;
  int          bad_count, num_checks, cyc, mbx_n, fifo_n, grant_n, busy_n;
  rcn_reset_nvmem_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mem_start, .mem_write, .mem_addr, .mem_wdata,
    .mem_owner_addon, .mem_done, .mem_fail, .mem_rdata, .addon_req, .addon_grant,
    .mbx_flag_reset, .rd_fifo_reset, .add_on_reset_out_n, .irq);
  rcn_mem_model u_mem (.clk(pclk), .start(mem_start), .wr(mem_write), .owner_addon(mem_owner_addon),
    .addr(mem_addr), .wdata(mem_wdata), .slow, .fail_en, .done(mem_done), .fail(mem_fail),
    .rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd     = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic nv(input logic [1:0] cmd, input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, RCN_CTRL_OFS, {3'h4, 5'h00, a[7:0], 16'h0000});
    apb(1'b1, RCN_CTRL_OFS, {3'h5, 5'h00, a[15:8], 16'h0000});
    apb(1'b1, RCN_CTRL_OFS, {1'b1, cmd, 5'h00, d, 16'h0000});
    busy_n = 0;
    do begin
      apb(1'b0, RCN_CTRL_OFS, 32'h0);
      if (rd[31] === 1'b1) busy_n++;
    end while (rd[31] !== 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (mbx_flag_reset === 1'b1) mbx_n++;
    if (rd_fifo_reset === 1'b1) fifo_n++;
    if (addon_grant === 1'b1) grant_n++;
    if (cyc == 3000) begin
      bad_count++;
      end_sim;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, addon_req, slow, fail_en} = '0;
    paddr  = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, RCN_CTRL_OFS, 32'h0);
    chk(rd, RCN_CTRL_RESET);
    apb(1'b1, RCN_CTRL_OFS, 32'h0f00_ffff);
    // fifo reset in operation wants idle cycles after it
    repeat (4) @(posedge pclk);
    chk(mbx_n, 1);
    chk(fifo_n, 1);
    chk({31'h0, add_on_reset_out_n}, 32'h0);
    apb(1'b0, RCN_CTRL_OFS, 32'h0);
    chk(rd, 32'h0100_0000);
    apb(1'b1, RCN_CTRL_OFS, 32'h0);
    chk({31'h0, add_on_reset_out_n}, 32'h1);
    apb(1'b1, RCN_IRQ_MASK_OFS, 32'h3);
    slow <= 1'b1;
    nv(RCN_CMD_WRITE, 16'h0134, 8'h5a);
    chk({31'h0, busy_n != 0}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, RCN_IRQ_STAT_OFS, 32'h0);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h0);
    nv(RCN_CMD_READ, 16'h0134, 8'h00);
    chk(rd, 32'h005a_0000);
    apb(1'b1, RCN_IRQ_MASK_OFS, 32'h0);
    fail_en <= 1'b1;
    nv(RCN_CMD_READ, 16'h0134, 8'h00);
    chk(rd & 32'h1000_0000, 32'h1000_0000);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, RCN_IRQ_STAT_OFS, 32'h0);
    chk(rd, 32'h3);
    fail_en <= 1'b0;
    nv(RCN_CMD_READ, 16'h0134, 8'h00);
    chk(rd, 32'h005a_0000);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, rd_err}, 32'h0);
    // add-on side only reads while the host works, so stored bytes stay intact
    slow      <= 1'b0;
    addon_req <= 1'b1;
    nv(RCN_CMD_READ, 16'h0134, 8'h00);
    addon_req <= 1'b0;
    chk(rd, 32'h005a_0000);
    chk({31'h0, grant_n != 0}, 32'h1);
    end_sim;
  end
endmodule
bind rcn_reset_nvmem_ctrl rcn_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .mbx_flag_reset, .rd_fifo_reset, .add_on_reset_out_n);
`default_nettype wire
